// file: inc/jid_pkg.sv
// jid_pkg: instruction codes, chain lengths and reset values for the
// test-port instruction decoder. Shared by decoder, interface and top.
package jid_pkg;
    localparam int IR_W = 10;
    localparam int IDC_W = 32;
    localparam int USR_W = 32;
    localparam int BOOT_W = 22;
    localparam int KEY_W = 512;
    localparam int BSR_W = 8;
    localparam int KEY_CLR_MIN = 10;

    localparam logic [IR_W-1:0] I_SAMPLE = 10'h005;
    localparam logic [IR_W-1:0] I_EXTEST = 10'h00F;
    localparam logic [IR_W-1:0] I_BYPASS = 10'h3FF;
    localparam logic [IR_W-1:0] I_USERCODE = 10'h007;
    localparam logic [IR_W-1:0] I_IDENT = 10'h006;
    localparam logic [IR_W-1:0] I_HIGHZ = 10'h00B;
    localparam logic [IR_W-1:0] I_CLAMP = 10'h00A;
    localparam logic [IR_W-1:0] I_RECONFIG = 10'h001;
    localparam logic [IR_W-1:0] I_IO_CFG = 10'h00D;
    localparam logic [IR_W-1:0] I_USR_CLK = 10'h1EE;
    localparam logic [IR_W-1:0] I_OSC_CLK = 10'h2EE;
    localparam logic [IR_W-1:0] I_CTRL_IDLE = 10'h2D0;
    localparam logic [IR_W-1:0] I_CTRL_ENG = 10'h2B0;
    localparam logic [IR_W-1:0] I_BOOT_ADDR = 10'h270;
    localparam logic [IR_W-1:0] I_UNLOCK = 10'h281;
    localparam logic [IR_W-1:0] I_KEY_ENTRY = 10'h1AD;
    localparam logic [IR_W-1:0] I_KEY_VCLR = 10'h029;
    localparam logic [IR_W-1:0] IR_CAPTURE = 10'h155;
    // identification value is arbitrary; bit 0 is forced to one
    localparam logic [IDC_W-1:0] IDCODE_DEF = 32'h1234_5679;

    typedef enum logic [2:0] {
        JID_SEL_BYP, JID_SEL_IDC, JID_SEL_USR, JID_SEL_BSR, JID_SEL_BOOT,
        JID_SEL_KEY
    } jid_sel_t;
endpackage

// file: inc/jid_ctl_if.sv
// jid_ctl_if: decoded instruction controls between decoder and top.
// assumes all signals live in the test clock domain.
`timescale 1ns/1ps
`default_nettype none
interface jid_ctl_if;
    import jid_pkg::*;
    jid_sel_t sel;
    logic ext_drive;
    logic hold_pins;
    logic pins_hiz;
    logic io_cfg;
    logic reconfig;
    logic usr_clk_on;
    logic usr_clk_off;
    logic idle_on;
    logic idle_off;
    logic unlock;
    logic key_clr;
    modport dec (output sel, ext_drive, hold_pins, pins_hiz, io_cfg,
        reconfig, usr_clk_on, usr_clk_off, idle_on, idle_off, unlock,
        key_clr);
    modport use_side (input sel, ext_drive, hold_pins, pins_hiz, io_cfg,
        reconfig, usr_clk_on, usr_clk_off, idle_on, idle_off, unlock,
        key_clr);
endinterface
`default_nettype wire

// file: hdl/jid_decode.sv
// jid_decode: turns the current instruction into chain select and
// actions. assumes the instruction is stable in the test clock domain.
`timescale 1ns/1ps
`default_nettype none
module jid_decode (
    // instruction and gating
    input wire logic [jid_pkg::IR_W-1:0] instr_i,
    input wire logic secure_i,
    input wire logic unlocked_i,
    input wire logic configuring_i,
    input wire logic cfg_paused_i,
    // decoded controls
    jid_ctl_if.dec ctl
);
    import jid_pkg::*;
    logic [IR_W-1:0] eff;
    logic ok;

    always_comb begin
        ok = 1'b1;
        // security variant: only mandatory ones and unlock before unlock
        if (secure_i && !unlocked_i) begin
            ok = (instr_i == I_BYPASS) || (instr_i == I_SAMPLE) ||
                 (instr_i == I_EXTEST) || (instr_i == I_UNLOCK) ||
                 (instr_i == I_IDENT);
        end
        // until paused, configuration allows only bypass, ident, sample, unlock, pause cmds
        if (configuring_i && !cfg_paused_i &&
            !((instr_i == I_BYPASS) || (instr_i == I_IDENT) ||
              (instr_i == I_SAMPLE) || (instr_i == I_IO_CFG) ||
              (instr_i == I_CTRL_IDLE) || (instr_i == I_UNLOCK))) begin
            ok = 1'b0;
        end
        if (secure_i && instr_i == I_BOOT_ADDR) begin
            ok = 1'b0;
        end
        if (!secure_i && (instr_i == I_UNLOCK || instr_i == I_KEY_ENTRY ||
            instr_i == I_KEY_VCLR)) begin
            ok = 1'b0;
        end
        eff = ok ? instr_i : I_BYPASS;
    end

    always_comb begin
        ctl.sel = JID_SEL_BYP;
        ctl.ext_drive = 1'b0;
        ctl.hold_pins = 1'b0;
        ctl.pins_hiz = 1'b0;
        ctl.io_cfg = 1'b0;
        ctl.reconfig = 1'b0;
        ctl.usr_clk_on = 1'b0;
        ctl.usr_clk_off = 1'b0;
        ctl.idle_on = 1'b0;
        ctl.idle_off = 1'b0;
        ctl.unlock = 1'b0;
        ctl.key_clr = 1'b0;
        case (eff)
            I_SAMPLE: ctl.sel = JID_SEL_BSR;
            I_EXTEST: begin
                ctl.sel = JID_SEL_BSR;
                ctl.ext_drive = 1'b1;
            end
            I_USERCODE: ctl.sel = JID_SEL_USR;
            I_IDENT: ctl.sel = JID_SEL_IDC;
            I_HIGHZ: ctl.pins_hiz = 1'b1;
            I_CLAMP: ctl.hold_pins = 1'b1;
            I_RECONFIG: ctl.reconfig = 1'b1;
            I_IO_CFG: ctl.io_cfg = 1'b1;
            I_USR_CLK: ctl.usr_clk_on = 1'b1;
            I_OSC_CLK: ctl.usr_clk_off = 1'b1;
            I_CTRL_IDLE: ctl.idle_on = 1'b1;
            I_CTRL_ENG: ctl.idle_off = 1'b1;
            I_BOOT_ADDR: ctl.sel = JID_SEL_BOOT;
            I_UNLOCK: ctl.unlock = 1'b1;
            I_KEY_ENTRY: ctl.sel = JID_SEL_KEY;
            I_KEY_VCLR: ctl.key_clr = 1'b1;
            default: ctl.sel = JID_SEL_BYP;
        endcase
    end
endmodule
`default_nettype wire

// file: hdl/jid_sync.sv
// jid_sync: two-flop level synchroniser into the test clock domain.
// assumes the input is a slow level from the system side.
`timescale 1ns/1ps
`default_nettype none
module jid_sync (
    // clock
    input wire logic clk_i,
    // level in and out
    input wire logic d_i,
    output logic q_o
);
    logic meta_reg;
    always_ff @(posedge clk_i) begin
        meta_reg <= d_i;
        q_o <= meta_reg;
    end
endmodule
`default_nettype wire

// file: hdl/jid_top.sv
// jid_top: test-port instruction register, data chains and pin control
// of a programmable device. assumes an external tap state machine gives
// state strobes on the test clock; system side runs on clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - sample/preload captures pins, preloads pattern
// - extest drives outputs, captures inputs
// - all-ones selects one-bit bypass
// - usercode shifts 32-bit user register
// - ident selected, default at reset
// - ident least significant bit is one
// - highz bypasses and floats all pins
// - clamp bypasses and holds boundary pins
// - reconfig instruction emulates request pulse
// - io config pauses configuration, loads chain; code only sets the pause, with bypass selected
// - clock source switch user/oscillator
// - controller idle and re-engage
// - boot address 22-bit chain, not secure
// - unlock opens instructions, clears config, key
// - key entry chain, output unconnected
// - key verify clear, ten cycles minimum
// - during config only bypass, ident, sample; code also accepts unlock, io config and idle
// - secure variant accepts only mandatory, unlock
// - secure ident default, others need unlock
// - instruction capture shifts alternating pattern
// - extest enable zero drives output cell
module jid_top (
    // system side
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic secure_i,
    input wire logic configuring_i,
    input wire logic [jid_pkg::USR_W-1:0] usercode_i,
    output logic cfg_clear_o,
    output logic reconfig_req_o,
    output logic cfg_paused_o,
    output logic usr_clk_sel_o,
    output logic ctrl_idle_o,
    output logic key_valid_o,
    output logic [jid_pkg::BOOT_W-1:0] boot_addr_o,
    output logic boot_addr_stb_o,
    // test link, strobes from the tap state machine
    input wire logic tck_i,
    input wire logic tap_reset_i,
    input wire logic tdi_i,
    input wire logic cap_ir_i,
    input wire logic shift_ir_i,
    input wire logic upd_ir_i,
    input wire logic cap_dr_i,
    input wire logic shift_dr_i,
    input wire logic upd_dr_i,
    output logic tdo_o,
    output logic tdo_oe_n_o,
    // boundary pins and key output
    input wire logic [jid_pkg::BSR_W-1:0] pin_in_i,
    input wire logic [jid_pkg::BSR_W-1:0] core_out_i,
    input wire logic [jid_pkg::BSR_W-1:0] core_oe_n_i,
    output logic [jid_pkg::BSR_W-1:0] pin_out_o,
    output logic [jid_pkg::BSR_W-1:0] pin_oe_n_o,
    output logic [jid_pkg::KEY_W-1:0] key_o
);
    import jid_pkg::*;
    jid_ctl_if ctl ();

    logic [IR_W-1:0] ir_sh_reg, ir_reg;
    logic byp_reg;
    logic [IDC_W-1:0] idc_reg;
    logic [USR_W-1:0] usr_reg;
    logic [BOOT_W-1:0] boot_reg;
    logic [KEY_W-1:0] key_reg;
    // boundary chain: per pin input, output, enable cells
    logic [3*BSR_W-1:0] bsr_reg, bsr_upd_reg;
    logic unlocked_reg, paused_reg;
    // marks the first cycle after an instruction update
    logic upd_q_reg;
    logic [3:0] clr_cnt_reg;
    logic sec_s, cfg_s, rst_s;
    logic rc_tgl_reg, clr_tgl_reg, key_ok_reg, boot_tgl_reg;
    logic [USR_W-1:0] usr_s;

    // system level inputs cross into the test clock domain
    jid_sync u_sec (.clk_i(tck_i), .d_i(secure_i), .q_o(sec_s));
    jid_sync u_cfg (.clk_i(tck_i), .d_i(configuring_i), .q_o(cfg_s));
    jid_sync u_rst (.clk_i(tck_i), .d_i(reset_n_i), .q_o(rst_s));
    genvar g;
    generate
        for (g = 0; g < USR_W; g++) begin : g_usr
            jid_sync u_u (.clk_i(tck_i), .d_i(usercode_i[g]),
                .q_o(usr_s[g]));
        end
    endgenerate

    jid_decode u_dec (
        .instr_i(ir_reg),
        .secure_i(sec_s),
        .unlocked_i(unlocked_reg),
        .configuring_i(cfg_s),
        .cfg_paused_i(paused_reg),
        .ctl(ctl)
    );

    // instruction register
    always_ff @(posedge tck_i) begin
        if (!rst_s || tap_reset_i) begin
            ir_sh_reg <= IR_CAPTURE;
            ir_reg <= I_IDENT;
        end else begin
            if (cap_ir_i) begin
                ir_sh_reg <= IR_CAPTURE;
            end else if (shift_ir_i) begin
                ir_sh_reg <= {tdi_i, ir_sh_reg[IR_W-1:1]};
            end
            if (upd_ir_i) begin
                ir_reg <= ir_sh_reg;
            end
        end
    end

    // data chains
    always_ff @(posedge tck_i) begin
        if (cap_dr_i) begin
            byp_reg <= 1'b0;
            idc_reg <= {IDCODE_DEF[IDC_W-1:1], 1'b1};
            usr_reg <= usr_s;
            for (int i = 0; i < BSR_W; i++) begin
                bsr_reg[3*i] <= pin_in_i[i];
                bsr_reg[3*i+1] <= core_out_i[i];
                bsr_reg[3*i+2] <= core_oe_n_i[i];
            end
        end else if (shift_dr_i) begin
            byp_reg <= tdi_i;
            idc_reg <= {tdi_i, idc_reg[IDC_W-1:1]};
            usr_reg <= {tdi_i, usr_reg[USR_W-1:1]};
            if (ctl.sel == JID_SEL_BSR) begin
                bsr_reg <= {tdi_i, bsr_reg[3*BSR_W-1:1]};
            end
            if (ctl.sel == JID_SEL_BOOT) begin
                boot_reg <= {tdi_i, boot_reg[BOOT_W-1:1]};
            end
            if (ctl.sel == JID_SEL_KEY) begin
                key_reg <= {tdi_i, key_reg[KEY_W-1:1]};
            end
        end
    end

    // boundary update cells, preloaded under sample or extest
    always_ff @(posedge tck_i) begin
        if (!rst_s) begin
            bsr_upd_reg <= '0;
        end else if (upd_dr_i && ctl.sel == JID_SEL_BSR) begin
            bsr_upd_reg <= bsr_reg;
        end
    end

    // pin muxing
    always_ff @(posedge tck_i) begin
        for (int i = 0; i < BSR_W; i++) begin
            if (ctl.pins_hiz) begin
                pin_oe_n_o[i] <= 1'b1;
                pin_out_o[i] <= 1'b0;
            end else if (ctl.ext_drive || ctl.hold_pins) begin
                pin_oe_n_o[i] <= bsr_upd_reg[3*i+2];
                pin_out_o[i] <= bsr_upd_reg[3*i+1];
            end else begin
                pin_oe_n_o[i] <= core_oe_n_i[i];
                pin_out_o[i] <= core_out_i[i];
            end
        end
    end

    // serial output on the falling edge
    always_ff @(negedge tck_i) begin
        if (shift_ir_i) begin
            tdo_o <= ir_sh_reg[0];
            tdo_oe_n_o <= 1'b0;
        end else if (shift_dr_i && ctl.sel != JID_SEL_KEY) begin
            tdo_oe_n_o <= 1'b0;
            unique case (ctl.sel)
                JID_SEL_IDC: tdo_o <= idc_reg[0];
                JID_SEL_USR: tdo_o <= usr_reg[0];
                JID_SEL_BSR: tdo_o <= bsr_reg[0];
                JID_SEL_BOOT: tdo_o <= boot_reg[0];
                default: tdo_o <= byp_reg;
            endcase
        end else begin
            tdo_o <= 1'b0;
            tdo_oe_n_o <= 1'b1;
        end
    end

    // configuration control state
    always_ff @(posedge tck_i) begin
        if (!rst_s) begin
            unlocked_reg <= 1'b0;
            paused_reg <= 1'b0;
            usr_clk_sel_o <= 1'b0;
            ctrl_idle_o <= 1'b0;
            rc_tgl_reg <= 1'b0;
            clr_tgl_reg <= 1'b0;
            boot_tgl_reg <= 1'b0;
            upd_q_reg <= 1'b0;
        end else begin
            upd_q_reg <= upd_ir_i;
            if (ctl.unlock && upd_ir_i == 1'b0 && !unlocked_reg) begin
                unlocked_reg <= 1'b1;
                clr_tgl_reg <= ~clr_tgl_reg;
            end
            if (ctl.io_cfg) begin
                paused_reg <= 1'b1;
            end
            if (ctl.idle_on) begin
                ctrl_idle_o <= 1'b1;
                paused_reg <= 1'b1;
            end
            if (ctl.idle_off) begin
                ctrl_idle_o <= 1'b0;
            end
            if (ctl.usr_clk_on) begin
                usr_clk_sel_o <= 1'b1;
            end
            if (ctl.usr_clk_off) begin
                usr_clk_sel_o <= 1'b0;
            end
            // decode shows the new code only after the update edge
            if (ctl.reconfig && upd_q_reg) begin
                rc_tgl_reg <= ~rc_tgl_reg;
                paused_reg <= 1'b0;
            end
            if (upd_dr_i && ctl.sel == JID_SEL_BOOT) begin
                boot_tgl_reg <= ~boot_tgl_reg;
            end
        end
    end

    // key verify clear counts test clocks while the instruction is held
    always_ff @(posedge tck_i) begin
        if (!rst_s) begin
            clr_cnt_reg <= '0;
            key_ok_reg <= 1'b0;
        end else if (ctl.key_clr || (ctl.unlock && !unlocked_reg)) begin
            if (clr_cnt_reg < 4'(KEY_CLR_MIN)) begin
                clr_cnt_reg <= clr_cnt_reg + 4'h1;
            end else begin
                key_ok_reg <= 1'b0;
            end
            if (ctl.unlock) begin
                key_ok_reg <= 1'b0;
            end
        end else begin
            clr_cnt_reg <= '0;
            if (upd_dr_i && ctl.sel == JID_SEL_KEY) begin
                key_ok_reg <= 1'b1;
            end
        end
    end

    assign key_o = key_reg;

    // checks on the test clock side
    reset_ident_a:
        assert property (@(posedge tck_i) disable iff (!rst_s)
            tap_reset_i |=> ir_reg == I_IDENT)
        else $error("ident not loaded by tap reset");
    ir_capture_a:
        assert property (@(posedge tck_i) disable iff (!rst_s)
            cap_ir_i && !tap_reset_i |=> ir_sh_reg == IR_CAPTURE)
        else $error("instruction capture pattern wrong");
    idc_lsb_a:
        assert property (@(posedge tck_i) disable iff (!rst_s)
            cap_dr_i |=> idc_reg[0] == 1'b1)
        else $error("ident lsb not one");
    hiz_pins_a:
        assert property (@(posedge tck_i) disable iff (!rst_s)
            ctl.pins_hiz |=> pin_oe_n_o == '1)
        else $error("pins driven under highz");
    boot_locked_a:
        assert property (@(posedge tck_i) disable iff (!rst_s)
            sec_s |-> ctl.sel != JID_SEL_BOOT)
        else $error("boot chain selected in secure variant");
    locked_byp_a:
        assert property (@(posedge tck_i) disable iff (!rst_s)
            sec_s && !unlocked_reg && ir_reg == I_USERCODE |->
            ctl.sel == JID_SEL_BYP)
        else $error("locked instruction not bypassed");
    key_tdo_a:
        assert property (@(negedge tck_i) disable iff (!rst_s)
            shift_dr_i && ctl.sel == JID_SEL_KEY |=> tdo_oe_n_o)
        else $error("serial out driven from key chain");

    // system side: events cross as toggles, levels through two flops
    logic [2:0] rc_s, clr_s, bt_s;
    logic pz_m, pz_s, ko_m, ko_s;
    always_ff @(posedge clk_sys_i) begin
        rc_s <= {rc_s[1:0], rc_tgl_reg};
        clr_s <= {clr_s[1:0], clr_tgl_reg};
        bt_s <= {bt_s[1:0], boot_tgl_reg};
        pz_m <= paused_reg;
        pz_s <= pz_m;
        ko_m <= key_ok_reg;
        ko_s <= ko_m;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            reconfig_req_o <= 1'b0;
            cfg_clear_o <= 1'b0;
            cfg_paused_o <= 1'b0;
            key_valid_o <= 1'b0;
            boot_addr_stb_o <= 1'b0;
            boot_addr_o <= '0;
        end else begin
            reconfig_req_o <= rc_s[2] ^ rc_s[1];
            cfg_clear_o <= clr_s[2] ^ clr_s[1];
            cfg_paused_o <= pz_s;
            key_valid_o <= ko_s;
            boot_addr_stb_o <= bt_s[2] ^ bt_s[1];
            if (bt_s[2] ^ bt_s[1]) begin
                boot_addr_o <= boot_reg;
            end
        end
    end

    // is kept by the board; no logic here
endmodule
`default_nettype wire

// file: test/jid_tester.sv
// jid_tester: boundary-scan tester that drives the test link frame by frame.
// assumes the decoder samples on rising tck and moves tdo on falling tck.
`timescale 1ns/1ps
`default_nettype none
module jid_tester (
    // test link out
    output logic tck_o,
    output logic tap_reset_o,
    output logic tdi_o,
    output logic cap_ir_o,
    output logic shift_ir_o,
    output logic upd_ir_o,
    output logic cap_dr_o,
    output logic shift_dr_o,
    output logic upd_dr_o,
    // test link in
    input wire logic tdo_i
);
    initial begin
        tck_o = 1'b0;
        tap_reset_o = 1'b0;
        tdi_o = 1'b1;
        {cap_ir_o, shift_ir_o, upd_ir_o} = 3'h0;
        {cap_dr_o, shift_dr_o, upd_dr_o} = 3'h0;
    end
    // tck runs only inside frames; one step is a fall, then a rise with
    // tdo taken just before it; strobes move 1 ns after the rise
    task automatic step(output logic t);
        #61.5;
        tck_o = 1'b0;
        #62.5;
        t = tdo_i;
        tck_o = 1'b1;
        #1;
    endtask
    task automatic tick(input int n);
        logic t;
        repeat (n) step(t);
    endtask
    task automatic treset();
        tap_reset_o <= 1'b1;
        tick(5);
        tap_reset_o <= 1'b0;
        tick(1);
    endtask
    // capture, shift n bits lsb first, update, then two idle steps
    task automatic scan(input logic ir, input int n, input logic [511:0] d,
        output logic [511:0] o);
        logic t;
        o = '0;
        cap_ir_o <= ir;
        cap_dr_o <= !ir;
        step(t);
        {cap_ir_o, cap_dr_o} <= 2'h0;
        shift_ir_o <= ir;
        shift_dr_o <= !ir;
        for (int i = 0; i < n; i++) begin
            tdi_o <= d[i];
            step(t);
            o[i] = t;
        end
        {shift_ir_o, shift_dr_o} <= 2'h0;
        tdi_o <= 1'b1;
        upd_ir_o <= ir;
        upd_dr_o <= !ir;
        step(t);
        {upd_ir_o, upd_dr_o} <= 2'h0;
        tick(2);
    endtask
endmodule
`default_nettype wire

// file: test/jid_top_test.sv
// jid_top_test: self-checking bench for the instruction decoder.
// assumes jid_tester drives the test link at a 125 ns tck.
`timescale 1ns/1ps
`default_nettype none
module jid_top_test;
    import jid_pkg::*;
    logic clk_sys_i = 1'b0, reset_n_i = 1'b0, secure_i = 1'b0;
    logic configuring_i = 1'b0;
    logic [USR_W-1:0] usercode_i = 32'hA5C3_0F96;
    logic [BSR_W-1:0] pin_in_i = 8'h96, core_out_i = 8'hFF;
    logic [BSR_W-1:0] core_oe_n_i = 8'h00;
    logic cfg_clear_o, reconfig_req_o, cfg_paused_o, usr_clk_sel_o;
    logic ctrl_idle_o, key_valid_o, boot_addr_stb_o, tdo_o, tdo_oe_n_o;
    logic [BOOT_W-1:0] boot_addr_o, boot_seen;
    logic [BSR_W-1:0] pin_out_o, pin_oe_n_o;
    logic [KEY_W-1:0] key_o;
    logic tck, trst, tdi, cir, sir, uir, cdr, sdr, udr;
    int err_total = 0, compares = 0, n_clr = 0, n_rcf = 0, n_boot = 0;
    logic [511:0] o;

    always #5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        if (cfg_clear_o === 1'b1) n_clr++;
        if (reconfig_req_o === 1'b1) n_rcf++;
        if (boot_addr_stb_o === 1'b1) begin
            n_boot++;
            boot_seen = boot_addr_o;
        end
    end

    jid_top jid_top_inst (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .secure_i(secure_i), .configuring_i(configuring_i),
        .usercode_i(usercode_i), .cfg_clear_o(cfg_clear_o),
        .reconfig_req_o(reconfig_req_o), .cfg_paused_o(cfg_paused_o),
        .usr_clk_sel_o(usr_clk_sel_o), .ctrl_idle_o(ctrl_idle_o),
        .key_valid_o(key_valid_o), .boot_addr_o(boot_addr_o),
        .boot_addr_stb_o(boot_addr_stb_o), .tck_i(tck), .tap_reset_i(trst),
        .tdi_i(tdi), .cap_ir_i(cir), .shift_ir_i(sir), .upd_ir_i(uir),
        .cap_dr_i(cdr), .shift_dr_i(sdr), .upd_dr_i(udr), .tdo_o(tdo_o),
        .tdo_oe_n_o(tdo_oe_n_o), .pin_in_i(pin_in_i),
        .core_out_i(core_out_i), .core_oe_n_i(core_oe_n_i),
        .pin_out_o(pin_out_o), .pin_oe_n_o(pin_oe_n_o), .key_o(key_o));
    jid_tester jid_tester_inst (.tck_o(tck), .tap_reset_o(trst),
        .tdi_o(tdi), .cap_ir_o(cir), .shift_ir_o(sir), .upd_ir_o(uir),
        .cap_dr_o(cdr), .shift_dr_o(sdr), .upd_dr_o(udr), .tdo_i(tdo_o));

    task automatic report_and_stop();
        $display("compares %0d errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input logic [511:0] seen, input logic [511:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen,
                exp);
        end
    endtask
    task automatic wait_eq(ref logic s, input logic v);
        for (int i = 0; i < 200 && s !== v; i++) @(posedge clk_sys_i);
        check(s, v);
        if (s !== v) report_and_stop();
    endtask
    task automatic wait_cnt(ref int c, input int e);
        for (int i = 0; i < 200 && c != e; i++) @(posedge clk_sys_i);
        check(c, e);
        if (c != e) report_and_stop();
    endtask
    task automatic ld(input logic [IR_W-1:0] code);
        jid_tester_inst.scan(1'b1, IR_W, 512'(code), o);
        check(o[IR_W-1:0], IR_CAPTURE);
    endtask
    task automatic dr(input int n, input logic [511:0] d);
        jid_tester_inst.scan(1'b0, n, d, o);
    endtask
    // bypass shows the data one stage late behind a captured zero
    task automatic byp();
        dr(8, 512'hC5);
        check(o[7:0], 8'h8A);
    endtask
    task automatic idc();
        dr(IDC_W, 512'h0);
        check(o[IDC_W-1:0], IDCODE_DEF);
        check(o[0], 1'b1);
    endtask
    task automatic usr_ok();
        ld(I_USERCODE);
        dr(USR_W, 512'h0);
        check(o[USR_W-1:0], usercode_i);
    endtask
    task automatic do_reset(input logic sec);
        @(posedge clk_sys_i);
        reset_n_i <= 1'b0;
        secure_i <= sec;
        jid_tester_inst.treset();
        repeat (20) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
    endtask

    task automatic t_plain();
        idc();
        ld(I_BYPASS);
        byp();
        ld(10'h3A5);
        byp();
        usr_ok();
    endtask
    task automatic t_config();
        @(posedge clk_sys_i);
        configuring_i <= 1'b1;
        ld(I_USERCODE);
        byp();
        ld(I_IDENT);
        idc();
        ld(I_IO_CFG);
        wait_eq(cfg_paused_o, 1'b1);
        usr_ok();
        ld(I_RECONFIG);
        wait_cnt(n_rcf, 1);
        @(posedge clk_sys_i);
        configuring_i <= 1'b0;
    endtask
    task automatic t_clk_ctrl();
        ld(I_USR_CLK);
        check(usr_clk_sel_o, 1'b1);
        ld(I_OSC_CLK);
        check(usr_clk_sel_o, 1'b0);
        ld(I_CTRL_IDLE);
        check(ctrl_idle_o, 1'b1);
        ld(I_CTRL_ENG);
        check(ctrl_idle_o, 1'b0);
    endtask
    task automatic t_boot(input logic sec);
        ld(I_BOOT_ADDR);
        if (sec) begin
            byp();
        end else begin
            dr(BOOT_W, 512'h2A_5C3F);
            wait_cnt(n_boot, 1);
            check(boot_seen, 22'h2A_5C3F);
        end
    endtask
    task automatic t_pins();
        ld(I_SAMPLE);
        dr(3 * BSR_W, 512'h0);
        check(pin_out_o, core_out_i);
        check(pin_oe_n_o, core_oe_n_i);
        ld(I_EXTEST);
        check(pin_out_o, 8'h00);
        check(pin_oe_n_o, 8'h00);
        ld(I_CLAMP);
        check(pin_out_o, 8'h00);
        byp();
        ld(I_HIGHZ);
        check(pin_oe_n_o, 8'hFF);
        byp();
    endtask
    task automatic t_secure();
        do_reset(1'b1);
        idc();
        ld(I_USERCODE);
        byp();
        t_boot(1'b1);
        ld(I_UNLOCK);
        wait_cnt(n_clr, 1);
        usr_ok();
        ld(I_KEY_ENTRY);
        dr(KEY_W, {16{32'hC3A5_960F}});
        check(key_o, {16{32'hC3A5_960F}});
        wait_eq(key_valid_o, 1'b1);
        ld(I_KEY_VCLR);
        jid_tester_inst.tick(KEY_CLR_MIN + 2);
        wait_eq(key_valid_o, 1'b0);
    endtask

    initial begin
        repeat (90000) @(posedge clk_sys_i);
        err_total++;
        report_and_stop();
    end
    initial begin
        do_reset(1'b0);
        t_plain();
        t_config();
        t_clk_ctrl();
        t_boot(1'b0);
        t_pins();
        t_secure();
        report_and_stop();
    end
endmodule
`default_nettype wire
